/* File: inc/serial_port_pkg.sv */
// Contract
// - Format field picks I2S, frame_sync_mode, right_justified or left_justified.
// - Word length field gives 16, 20, 24 or 32 bits per channel.
// - Bit clock direction bit: 0 accept bit_clock, 1 drive it.
// - Word clock direction bit: 0 accept word_clock, 1 drive it.
// - Data pin floats when idle only if tri-state enable is set.
// - Channel data starts 0 to 255 bit clocks late; frame sync from word rise.
// - Inversion bit flips bit clock sense for primary and secondary clocks.
// - Keep-alive bit keeps clocks running while the converter is powered down.
// - Divider input: code 10 converter clock, 11 modulator clock, others reserved.
// - Bit clock divider runs only while its power-up bit is one.
// - Ratio field divides by 1 to 127; zero divides by 128. A ratio of one holds the bit clock low.
// - Secondary bit clock comes from pin one (00) or pin two (01).
// - Secondary word clock comes from pin one (00) or pin two (01).
// - Select bit picks primary or secondary bit clock for the interface.
// - Select bit picks primary or secondary word clock for the interface.
// - Primary bit clock pin carries internal clock (0) or secondary clock (1).
// - Secondary bit clock output forwards primary (0) or internal clock (1).
// - Primary word clock out: internal sample rate (01) or secondary (10).
// - Secondary word clock out: primary (00) or internal sample rate (10).
// - Without slot mode both channels use first delay, but in frame sync the second follows the first at once; with it, the second channel uses the second delay.
package serial_port_pkg;
	// ==================================================
	// Register offsets, write masks and reset values
	localparam logic [7:0] OFF_FORMAT = 8'h1b;
	localparam logic [7:0] OFF_DELAY1 = 8'h1c;
	localparam logic [7:0] OFF_CLKCTL = 8'h1d;
	localparam logic [7:0] OFF_NDIV = 8'h1e;
	localparam logic [7:0] OFF_PINSEL = 8'h1f;
	localparam logic [7:0] OFF_SRCSEL = 8'h20;
	localparam logic [7:0] OFF_ROUTE = 8'h21;
	localparam logic [7:0] OFF_DELAY2 = 8'h25;
	localparam logic [7:0] OFF_SLOTCTL = 8'h26;
	localparam logic [7:0] MASK_FORMAT = 8'hfd;
	localparam logic [7:0] MASK_PINSEL = 8'h7e;
	localparam logic [7:0] MASK_SRCSEL = 8'h0c;
	localparam logic [7:0] MASK_ROUTE = 8'hfc;
	localparam logic [7:0] MASK_SLOTCTL = 8'h1f;
	localparam logic [7:0] RST_CLKCTL = 8'h02;
	localparam logic [7:0] RST_NDIV = 8'h01;
	localparam logic [7:0] RST_ROUTE = 8'h10;
	localparam logic [7:0] RST_SLOTCTL = 8'h02;
	// ==================================================
	// Field positions
	localparam int FMT_HI = 7;
	localparam int FMT_LO = 6;
	localparam int WL_HI = 5;
	localparam int WL_LO = 4;
	localparam int BDIR_BIT = 3;
	localparam int WDIR_BIT = 2;
	localparam int TRI_BIT = 0;
	localparam int INV_BIT = 3;
	localparam int KEEP_BIT = 2;
	localparam int NPWR_BIT = 7;
	localparam int BPIN_HI = 6;
	localparam int BPIN_LO = 5;
	localparam int WPIN_HI = 4;
	localparam int WPIN_LO = 3;
	localparam int BSEC_BIT = 3;
	localparam int WSEC_BIT = 2;
	localparam int PBOUT_BIT = 7;
	localparam int SBOUT_BIT = 6;
	localparam int PWOUT_HI = 5;
	localparam int PWOUT_LO = 4;
	localparam int SWOUT_HI = 3;
	localparam int SWOUT_LO = 2;
	localparam int SLOT_BIT = 0;
	// ==================================================
	// Codes
	localparam logic [1:0] FMT_I2S = 2'h0;
	localparam logic [1:0] FMT_FSYNC = 2'h1;
	localparam logic [1:0] FMT_RJ = 2'h2;
	localparam logic [1:0] FMT_LJ = 2'h3;
	localparam logic [1:0] SRC_CONV = 2'h2;
	localparam logic [1:0] SRC_MOD = 2'h3;
	localparam logic [1:0] PIN_ONE = 2'h0;
	localparam logic [1:0] PIN_TWO = 2'h1;
	localparam logic [1:0] WOUT_INT = 2'h1;
	localparam logic [1:0] WOUT_SEC = 2'h2;
	localparam logic [1:0] WOUT_PRIM = 2'h0;
	localparam logic [7:0] DIV_ZERO_RATIO = 8'h80;
	localparam logic [8:0] I2S_LEAD = 9'h001;
	typedef enum logic [2:0] {
		IDLE = 3'b001,
		DELAY = 3'b010,
		SHIFT = 3'b100
	} tx_state_e;
endpackage

/* File: hdl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] q1;
		logic [W-1:0] q2;
	} sync_s;
	sync_s s;
	sync_s next_s;

	// The first stage feeds only the second; nothing else reads it.
	always_comb begin
		next_s.q1 = d;
		next_s.q2 = s.q1;
	end

	// Both stages clear under reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.q2;
endmodule

/* File: hdl/bit_clock_gen.sv */
`timescale 1ns/1ps
module bit_clock_gen (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic src_tick,
	input wire logic [6:0] ratio,
	// Output level
	output logic bclk
);
	typedef struct packed {
		logic [6:0] cnt;
		logic bclk;
	} div_s;
	div_s s;
	div_s next_s;
	logic [7:0] n;
	logic [7:0] half;
	logic [7:0] inc;

	// A zero ratio stands for the longest division.
	always_comb begin
		n = (ratio == 7'h00) ? serial_port_pkg::DIV_ZERO_RATIO : {1'b0, ratio};
		half = n >> 1;
		inc = {1'b0, s.cnt} + 8'h01;
	end

	// Count source ticks; the level is high for the first half period.
	// A ratio of one cannot make a square wave and leaves the level low.
	always_comb begin
		next_s = s;
		if (!run) begin
			next_s = '0;
		end else if (src_tick) begin
			next_s.cnt = (inc == n) ? 7'h00 : inc[6:0];
		end
		next_s.bclk = run && ({1'b0, next_s.cnt} < half);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign bclk = s.bclk;

	// ==================================================
	// Checks
	divider_off_a: assert property (@(posedge clk) disable iff (!rst_n) !run |=> !bclk && s.cnt == 7'h00)
		else $error("bit clock divider runs while powered down");
	ratio_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
		run && $stable(ratio) && ratio == 7'h00 && src_tick && s.cnt == 7'h7f |=> s.cnt == 7'h00)
		else $error("zero ratio does not wrap after 128 ticks");
endmodule

/* File: hdl/serial_port.sv */
`timescale 1ns/1ps
module serial_port (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Clock tree and converter
	input wire logic converter_clock_tick,
	input wire logic modulator_clock_tick,
	input wire logic sample_rate_clock,
	input wire logic converter_powered,
	input wire logic [31:0] left_sample,
	input wire logic [31:0] right_sample,
	// Primary bit and word clock pins
	input wire logic bit_clock_in,
	output logic bit_clock_out,
	output logic bit_clock_oe,
	input wire logic word_clock_in,
	output logic word_clock_out,
	output logic word_clock_oe,
	// General pins
	input wire logic general_pin_one_in,
	output logic general_pin_one_out,
	output logic general_pin_one_oe,
	input wire logic general_pin_two_in,
	output logic general_pin_two_out,
	output logic general_pin_two_oe,
	// Serial data pin
	output logic serial_data_out,
	output logic serial_data_oe
);
	typedef struct packed {
		logic [7:0] fmt;
		logic [7:0] dly1;
		logic [7:0] clkctl;
		logic [7:0] ndiv;
		logic [7:0] pinsel;
		logic [7:0] srcsel;
		logic [7:0] route;
		logic [7:0] dly2;
		logic [7:0] slotctl;
		logic [7:0] rdata;
		logic prev_b;
		logic prev_w;
		serial_port_pkg::tx_state_e st;
		logic ch;
		logic [31:0] sh;
		logic [4:0] bits;
		logic [9:0] dly;
		logic [8:0] half;
		logic [8:0] last_half;
		logic dout;
	} port_s;
	port_s s;
	port_s next_s;
	logic rst_n;
	logic [3:0] pins;
	logic g1, g2, pb, pw;
	logic int_bclk, inv, clk_run, src_tick;
	logic sec_b, sec_w, eff_b, eff_w, launch;
	logic int_w, prim_b_val, sec_b_val, prim_w_val, sec_w_val;
	logic drive_sec_b, drive_sec_w;
	logic [1:0] mode;
	logic [5:0] wl;
	logic go;
	logic [9:0] ld;
	logic [8:0] base;
	logic [31:0] word;

	// ==================================================
	// Reset release and pin synchronisers
	pin_sync #(.W(1)) rst_sync (.clk(clk), .rst_n(nrst), .d(1'b1), .q(rst_n));
	pin_sync #(.W(4)) in_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({general_pin_two_in, general_pin_one_in, word_clock_in, bit_clock_in}),
		.q(pins)
	);
	assign {g2, g1, pw, pb} = pins;

	// ==================================================
	// Bit clock divider
	always_comb begin
		unique case (s.clkctl[1:0])
			serial_port_pkg::SRC_CONV: src_tick = converter_clock_tick;
			serial_port_pkg::SRC_MOD: src_tick = modulator_clock_tick;
			default: src_tick = 1'b0;
		endcase
	end
	// Clocks stop with the converter unless keep-alive holds them up.
	assign clk_run = converter_powered || s.clkctl[serial_port_pkg::KEEP_BIT];
	bit_clock_gen divider (
		.clk(clk),
		.rst_n(rst_n),
		.run(s.ndiv[serial_port_pkg::NPWR_BIT] && clk_run),
		.src_tick(src_tick),
		.ratio(s.ndiv[6:0]),
		.bclk(int_bclk)
	);

	// ==================================================
	// Clock routing, selection and pin drive
	always_comb begin
		inv = s.clkctl[serial_port_pkg::INV_BIT];
		int_w = sample_rate_clock && clk_run;
		mode = s.fmt[serial_port_pkg::FMT_HI:serial_port_pkg::FMT_LO];
		unique case (s.pinsel[serial_port_pkg::BPIN_HI:serial_port_pkg::BPIN_LO])
			serial_port_pkg::PIN_ONE: sec_b = g1;
			serial_port_pkg::PIN_TWO: sec_b = g2;
			default: sec_b = 1'b0;
		endcase
		unique case (s.pinsel[serial_port_pkg::WPIN_HI:serial_port_pkg::WPIN_LO])
			serial_port_pkg::PIN_ONE: sec_w = g1;
			serial_port_pkg::PIN_TWO: sec_w = g2;
			default: sec_w = 1'b0;
		endcase
		prim_b_val = s.route[serial_port_pkg::PBOUT_BIT] ? sec_b : (int_bclk ^ inv);
		sec_b_val = s.route[serial_port_pkg::SBOUT_BIT] ? (int_bclk ^ inv) : pb;
		unique case (s.route[serial_port_pkg::PWOUT_HI:serial_port_pkg::PWOUT_LO])
			serial_port_pkg::WOUT_SEC: prim_w_val = sec_w;
			default: prim_w_val = int_w;
		endcase
		unique case (s.route[serial_port_pkg::SWOUT_HI:serial_port_pkg::SWOUT_LO])
			serial_port_pkg::WOUT_PRIM: sec_w_val = pw;
			default: sec_w_val = int_w;
		endcase
		// Secondary outputs drive a pin only when routed from inside.
		drive_sec_b = s.route[serial_port_pkg::SBOUT_BIT] && !s.srcsel[serial_port_pkg::BSEC_BIT];
		drive_sec_w = (s.route[serial_port_pkg::SWOUT_HI:serial_port_pkg::SWOUT_LO] == serial_port_pkg::WOUT_SEC)
			&& !s.srcsel[serial_port_pkg::WSEC_BIT];
		// Levels the serial engine follows; inversion changes the launch edge.
		if (s.srcsel[serial_port_pkg::BSEC_BIT]) begin
			eff_b = sec_b ^ inv;
		end else begin
			eff_b = (s.fmt[serial_port_pkg::BDIR_BIT] ? int_bclk : pb) ^ inv;
		end
		if (s.srcsel[serial_port_pkg::WSEC_BIT]) begin
			eff_w = sec_w;
		end else begin
			eff_w = s.fmt[serial_port_pkg::WDIR_BIT] ? int_w : pw;
		end
	end

	// Pin outputs; reserved select codes leave both general pins undriven.
	assign bit_clock_out = prim_b_val;
	assign bit_clock_oe = s.fmt[serial_port_pkg::BDIR_BIT];
	assign word_clock_out = prim_w_val;
	assign word_clock_oe = s.fmt[serial_port_pkg::WDIR_BIT];
	assign general_pin_one_oe = (drive_sec_b && s.pinsel[6:5] == serial_port_pkg::PIN_ONE)
		|| (drive_sec_w && s.pinsel[4:3] == serial_port_pkg::PIN_ONE);
	assign general_pin_two_oe = (drive_sec_b && s.pinsel[6:5] == serial_port_pkg::PIN_TWO)
		|| (drive_sec_w && s.pinsel[4:3] == serial_port_pkg::PIN_TWO);
	assign general_pin_one_out = (drive_sec_b && s.pinsel[6:5] == serial_port_pkg::PIN_ONE) ? sec_b_val : sec_w_val;
	assign general_pin_two_out = (drive_sec_b && s.pinsel[6:5] == serial_port_pkg::PIN_TWO) ? sec_b_val : sec_w_val;
	assign serial_data_out = s.dout;
	// Idle data floats only on request, so a shared line is not fought over.
	assign serial_data_oe = !(s.fmt[serial_port_pkg::TRI_BIT] && s.st == serial_port_pkg::IDLE);
	assign reg_rdata = s.rdata;

	// ==================================================
	// Registers and serial engine
	always_comb begin
		next_s = s;
		go = 1'b0;
		ld = '0;
		word = '0;
		launch = s.prev_b && !eff_b;
		unique case (s.fmt[serial_port_pkg::WL_HI:serial_port_pkg::WL_LO])
			2'h0: wl = 6'd16;
			2'h1: wl = 6'd20;
			2'h2: wl = 6'd24;
			default: wl = 6'd32;
		endcase
		// Right-justified data ends on the last bit clock of its half, sized from the previous half.
		base = (s.last_half > {3'h0, wl}) ? (s.last_half - {3'h0, wl}) : 9'h000;
		next_s.prev_b = eff_b;
		if (reg_rd) begin
			unique case (reg_addr)
				serial_port_pkg::OFF_FORMAT: next_s.rdata = s.fmt;
				serial_port_pkg::OFF_DELAY1: next_s.rdata = s.dly1;
				serial_port_pkg::OFF_CLKCTL: next_s.rdata = s.clkctl;
				serial_port_pkg::OFF_NDIV: next_s.rdata = s.ndiv;
				serial_port_pkg::OFF_PINSEL: next_s.rdata = s.pinsel;
				serial_port_pkg::OFF_SRCSEL: next_s.rdata = s.srcsel;
				serial_port_pkg::OFF_ROUTE: next_s.rdata = s.route;
				serial_port_pkg::OFF_DELAY2: next_s.rdata = s.dly2;
				serial_port_pkg::OFF_SLOTCTL: next_s.rdata = s.slotctl;
				default: next_s.rdata = 8'h00;
			endcase
		end
		// Read-only reserved bits are masked; software keeps reserved codes out.
		if (reg_wr) begin
			unique case (reg_addr)
				serial_port_pkg::OFF_FORMAT: next_s.fmt = reg_wdata & serial_port_pkg::MASK_FORMAT;
				serial_port_pkg::OFF_DELAY1: next_s.dly1 = reg_wdata;
				serial_port_pkg::OFF_CLKCTL: next_s.clkctl = reg_wdata;
				serial_port_pkg::OFF_NDIV: next_s.ndiv = reg_wdata;
				serial_port_pkg::OFF_PINSEL: next_s.pinsel = reg_wdata & serial_port_pkg::MASK_PINSEL;
				serial_port_pkg::OFF_SRCSEL: next_s.srcsel = reg_wdata & serial_port_pkg::MASK_SRCSEL;
				serial_port_pkg::OFF_ROUTE: next_s.route = reg_wdata & serial_port_pkg::MASK_ROUTE;
				serial_port_pkg::OFF_DELAY2: next_s.dly2 = reg_wdata;
				serial_port_pkg::OFF_SLOTCTL: next_s.slotctl = reg_wdata & serial_port_pkg::MASK_SLOTCTL;
				default: ;
			endcase
		end
		if (launch) begin
			next_s.prev_w = eff_w;
			if (eff_w != s.prev_w && (mode != serial_port_pkg::FMT_FSYNC || eff_w)) begin
				// A word clock edge restarts the frame, even mid-word; frame sync ignores the fall.
				next_s.half = '0;
				next_s.last_half = s.half + 9'h001;
				next_s.st = serial_port_pkg::IDLE;
				next_s.dout = 1'b0;
				if (mode != serial_port_pkg::FMT_FSYNC || eff_w) begin
					go = 1'b1;
					next_s.ch = (mode == serial_port_pkg::FMT_I2S) ? eff_w : !eff_w;
					if (mode == serial_port_pkg::FMT_FSYNC) begin
						next_s.ch = 1'b0;
					end
					unique case (mode)
						serial_port_pkg::FMT_I2S: ld = {1'b0, serial_port_pkg::I2S_LEAD};
						serial_port_pkg::FMT_RJ: ld = {1'b0, base};
						default: ld = '0;
					endcase
					if (next_s.ch && s.slotctl[serial_port_pkg::SLOT_BIT]) begin
						ld = ld + {2'h0, s.dly2};
					end else begin
						ld = ld + {2'h0, s.dly1};
					end
				end
			end else begin
				next_s.half = (s.half == 9'h1ff) ? s.half : s.half + 9'h001;
				unique case (s.st)
					serial_port_pkg::IDLE: ;
					serial_port_pkg::DELAY: begin
						if (s.dly == 10'h001) begin
							go = 1'b1;
						end else begin
							next_s.dly = s.dly - 10'h001;
						end
					end
					serial_port_pkg::SHIFT: begin
						if (s.bits != 5'h00) begin
							next_s.dout = s.sh[31];
							next_s.sh = {s.sh[30:0], 1'b0};
							next_s.bits = s.bits - 5'h01;
						end else if (mode == serial_port_pkg::FMT_FSYNC && !s.ch) begin
							// The second channel follows the first in frame sync.
							go = 1'b1;
							next_s.ch = 1'b1;
							ld = s.slotctl[serial_port_pkg::SLOT_BIT] ? {2'h0, s.dly2} : 10'h000;
							next_s.st = serial_port_pkg::IDLE;
							next_s.dout = 1'b0;
						end else begin
							next_s.st = serial_port_pkg::IDLE;
							next_s.dout = 1'b0;
						end
					end
					default: next_s.st = serial_port_pkg::IDLE;
				endcase
			end
		end
		if (go) begin
			if (ld == 10'h000 || s.st == serial_port_pkg::DELAY && ld == 10'h000 && !launch) begin
				next_s.st = serial_port_pkg::SHIFT;
			end
			// A restart must not load at once just because an old delay was about to expire.
			if (ld == 10'h000) begin
				word = next_s.ch ? right_sample : left_sample;
				next_s.st = serial_port_pkg::SHIFT;
				next_s.dout = word[31];
				next_s.sh = {word[30:0], 1'b0};
				next_s.bits = 5'(wl - 6'd1);
			end else begin
				next_s.st = serial_port_pkg::DELAY;
				next_s.dly = ld;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{fmt: 8'h00, dly1: 8'h00, clkctl: serial_port_pkg::RST_CLKCTL, ndiv: serial_port_pkg::RST_NDIV,
				pinsel: 8'h00, srcsel: 8'h00, route: serial_port_pkg::RST_ROUTE, dly2: 8'h00,
				slotctl: serial_port_pkg::RST_SLOTCTL, rdata: 8'h00, prev_b: 1'b0, prev_w: 1'b0,
				st: serial_port_pkg::IDLE, ch: 1'b0, sh: 32'h0000_0000, bits: 5'h00, dly: 10'h000,
				half: 9'h000, last_half: 9'h000, dout: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	// ==================================================
	// Checks
	sequence fmt_write;
		reg_wr && reg_addr == serial_port_pkg::OFF_FORMAT;
	endsequence
	sequence word_start;
		s.st != serial_port_pkg::SHIFT ##1 s.st == serial_port_pkg::SHIFT;
	endsequence
	bclk_direction_a: assert property (@(posedge clk) disable iff (!rst_n)
		fmt_write |=> bit_clock_oe == $past(reg_wdata[3]))
		else $error("bit clock drive does not follow direction bit");
	wclk_direction_a: assert property (@(posedge clk) disable iff (!rst_n)
		fmt_write |=> word_clock_oe == $past(reg_wdata[2]))
		else $error("word clock drive does not follow direction bit");
	data_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
		!s.fmt[0] || s.st != serial_port_pkg::IDLE |-> serial_data_oe)
		else $error("data pin released while it must be driven");
	word_length_a: assert property (@(posedge clk) disable iff (!rst_n)
		word_start |-> {1'b0, s.bits} == wl - 6'd1)
		else $error("word length count wrong at word start");
	frame_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
		launch && eff_w && !s.prev_w && mode == serial_port_pkg::FMT_FSYNC && s.dly1 > 8'h01
		|=> s.st == serial_port_pkg::DELAY && s.dly == {2'h0, $past(s.dly1)})
		else $error("frame sync delay not loaded from first offset");
	keep_alive_a: assert property (@(posedge clk) disable iff (!rst_n)
		!clk_run |-> !int_w ##1 !int_bclk)
		else $error("word clock runs while converter is down");
	primary_route_a: assert property (@(posedge clk) disable iff (!rst_n)
		s.route[7] |-> bit_clock_out == sec_b)
		else $error("primary bit clock does not forward secondary");
	second_route_a: assert property (@(posedge clk) disable iff (!rst_n)
		s.route[3:2] == serial_port_pkg::WOUT_PRIM |-> sec_w_val == pw)
		else $error("secondary word clock does not forward primary");
endmodule

/* File: verif/host_port.sv */
`timescale 1ns/1ps
// ==================================================
// Host serial port: makes the bit and word clocks and collects whole frames.
module host_port (
	// Clock and control
	input wire logic clk,
	input wire logic run,
	input wire logic [1:0] fmt,
	// Data pin
	input wire logic sdata,
	input wire logic soe,
	// Clocks and captured frame
	output logic bclk,
	output logic wclk,
	output logic [63:0] frame,
	output logic [7:0] nframes
);
	logic [3:0] ph;
	logic [5:0] cnt;
	logic [63:0] sh;

	// Word level of a slot: I2S sends left while low, frame sync pulses once.
	function automatic logic word(input logic [5:0] c);
		if (fmt == serial_port_pkg::FMT_I2S) return c[5];
		if (fmt == serial_port_pkg::FMT_FSYNC) return c == 6'h00;
		return !c[5];
	endfunction

	// Start from rest so the first frame is plainly discarded.
	initial begin
		{ph, cnt, sh, frame, nframes, bclk, wclk} = '0;
	end

	// Clocks stand still between runs; a floating data pin reads as the inverse of the last bit.
	always @(posedge clk) begin
		if (!run) begin
			ph <= 4'h0;
			cnt <= 6'h00;
			bclk <= 1'b0;
			wclk <= word(6'h00);
		end else begin
			ph <= ph + 4'h1;
			if (ph == 4'h7) begin
				bclk <= 1'b1;
				sh <= {sh[62:0], soe ? sdata : ~sh[0]};
			end
			if (ph == 4'hf) begin
				bclk <= 1'b0;
				cnt <= cnt + 6'h01;
				wclk <= word(cnt + 6'h01);
				if (cnt == 6'h3f) begin
					frame <= sh;
					nframes <= nframes + 8'h01;
				end
			end
		end
	end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
// ==================================================
// Bench top: register table, clock generation and routing, serial frames.
module tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic mod_tick = 1'b0;
	logic srate = 1'b0;
	logic powered = 1'b1;
	logic gp1 = 1'b0;
	logic gp2 = 1'b0;
	logic run = 1'b0;
	logic [31:0] left = 32'hc3a5_96e1;
	logic [31:0] right = 32'h5a3c_0f87;
	logic [7:0] reg_rdata, rd, nframes;
	logic bo, boe, wo, woe, host_b, host_w, g1o, g1oe, g2o, g2oe, sdo, sdoe;
	logic [63:0] frame;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	// Rows of write flag, offset, write data and expected readback.
	localparam logic [24:0] REGS [20] = '{25'h01b_0000, 25'h01c_0000, 25'h01d_0002, 25'h01e_0001,
		25'h01f_0000, 25'h020_0000, 25'h021_0010, 25'h025_0000, 25'h026_0002, 25'h022_0000,
		25'h11b_0200, 25'h11c_ffff, 25'h11d_0b0b, 25'h11e_8080, 25'h11f_2928, 25'h120_0e0c,
		25'h121_aba8, 25'h125_ffff, 25'h126_0101, 25'h123_5500};
	// Frame rows of format, word length code and first delay.
	localparam logic [11:0] FRAMES [5] = '{12'hf00, 12'he03, 12'h200, 12'h900, 12'h402};

	// Each pin input sees the device while it drives; otherwise clock pins see the host and general pins see gp1 and gp2.
	serial_port dut_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .converter_clock_tick(1'b1),
		.modulator_clock_tick(mod_tick), .sample_rate_clock(srate), .converter_powered(powered),
		.left_sample(left), .right_sample(right), .bit_clock_in(boe ? bo : host_b),
		.bit_clock_out(bo), .bit_clock_oe(boe), .word_clock_in(woe ? wo : host_w),
		.word_clock_out(wo), .word_clock_oe(woe), .general_pin_one_in(g1oe ? g1o : gp1),
		.general_pin_one_out(g1o), .general_pin_one_oe(g1oe), .general_pin_two_in(g2oe ? g2o : gp2),
		.general_pin_two_out(g2o), .general_pin_two_oe(g2oe), .serial_data_out(sdo),
		.serial_data_oe(sdoe));
	logic [1:0] cur_fmt = 2'h0;
	host_port host_u (.clk(clk), .run(run), .fmt(cur_fmt),
		.sdata(sdo), .soe(sdoe), .bclk(host_b), .wclk(host_w), .frame(frame), .nframes(nframes));

	// Free running clock; the modulator tick runs at half the converter rate.
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		mod_tick <= ~mod_tick;
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			$display("[FAIL] %0t run took too long", $time);
			test_done();
		end
	end

	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		#1 {reg_rd, reg_addr} = {1'b1, a};
		@(posedge clk);
		#1 reg_rd = 1'b0;
		rd = reg_rdata;
	endtask
	task automatic do_reset();
		#1 nrst = 1'b0;
		repeat (5) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (6) @(posedge clk);
	endtask
	// Counts rising edges of the primary bit clock or of general pin one.
	task automatic rises(input logic sel, input int len, input int lo, input int hi, input string msg);
		logic prev;
		logic cur;
		n = 0;
		prev = sel ? g1o : bo;
		repeat (len) begin
			@(posedge clk);
			#1 cur = sel ? g1o : bo;
			if (cur && !prev) n++;
			prev = cur;
		end
		check(64'(n >= lo && n <= hi), 64'h1, msg);
	endtask
	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Expected frame, MSB first, both channels placed from the format, and from the delay in left-justified and frame sync only.
	function automatic logic [63:0] exp_frame(input logic [11:0] r);
		logic [63:0] f;
		int wl;
		int s;
		int t;
		f = 64'h0;
		wl = (r[9:8] == 2'h3) ? 32 : 16 + 4 * r[9:8];
		s = (r[11:10] == serial_port_pkg::FMT_I2S) ? 1 : (r[11:10] == serial_port_pkg::FMT_RJ) ? 32 - wl : r[7:0];
		// Frame sync without slot mode puts the right word straight after the left one.
		t = (r[11:10] == serial_port_pkg::FMT_FSYNC) ? s + wl : 32 + s;
		for (int i = 0; i < wl; i++) begin
			f[63 - s - i] = left[31 - i];
			f[63 - t - i] = right[31 - i];
		end
		return f;
	endfunction
	task automatic test_done();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main sequence; a second reset in mid-run starts the hand-written cases.
	initial begin
		do_reset();
		foreach (REGS[i]) begin
			if (REGS[i][24]) wr(REGS[i][23:16], REGS[i][15:8]);
			rdr(REGS[i][23:16]);
			check(64'(rd), 64'(REGS[i][7:0]), "register readback");
		end
		$display("test registers done");
		do_reset();
		check(64'({boe, woe, sdoe}), 64'h1, "pin enables after reset");
		wr(8'h1b, 8'h0d);
		settle(2);
		check(64'({boe, woe, sdoe}), 64'h6, "pin enables when driving");
		wr(8'h1e, 8'h84);
		rises(0, 80, 19, 21, "divide by four");
		wr(8'h1d, 8'h03);
		rises(0, 80, 9, 11, "modulator source");
		wr(8'h1d, 8'h02);
		powered = 1'b0;
		rises(0, 80, 0, 0, "clock stops at power down");
		wr(8'h1d, 8'h06);
		rises(0, 80, 19, 21, "clock kept alive");
		powered = 1'b1;
		wr(8'h1d, 8'h02);
		wr(8'h1e, 8'h80);
		rises(0, 300, 2, 3, "zero ratio divides by 128");
		wr(8'h1e, 8'h04);
		rises(0, 80, 0, 0, "divider off");
		wr(8'h1e, 8'h81);
		settle(4);
		check(64'(bo), 64'h0, "ratio one stuck low");
		wr(8'h1d, 8'h0a);
		settle(4);
		check(64'(bo), 64'h1, "inverted bit clock");
		wr(8'h1d, 8'h02);
		wr(8'h1e, 8'h84);
		$display("test divider done");
		wr(8'h21, 8'h50);
		rises(1, 80, 19, 21, "internal clock on pin one");
		wr(8'h21, 8'h90);
		gp1 = 1'b1;
		settle(6);
		check(64'({g1oe, bo}), 64'h1, "secondary high forwarded");
		gp1 = 1'b0;
		settle(6);
		check(64'(bo), 64'h0, "secondary low forwarded");
		wr(8'h1f, 8'h20);
		gp2 = 1'b1;
		settle(6);
		check(64'(bo), 64'h1, "secondary from pin two");
		wr(8'h21, 8'h10);
		srate = 1'b1;
		settle(3);
		check(64'(wo), 64'h1, "word out follows sample rate");
		srate = 1'b0;
		wr(8'h1f, 8'h08);
		wr(8'h21, 8'h20);
		settle(6);
		check(64'(wo), 64'h1, "word out forwards pin two");
		gp2 = 1'b0;
		wr(8'h1f, 8'h00);
		wr(8'h21, 8'h18);
		check(64'({g1oe, g1o}), 64'h2, "pin one carries sample rate low");
		srate = 1'b1;
		settle(3);
		check(64'({g1oe, g1o}), 64'h3, "pin one carries sample rate high");
		$display("test routing done");
		wr(8'h21, 8'h10);
		foreach (FRAMES[i]) begin
			cur_fmt = FRAMES[i][11:10];
			wr(8'h1b, FRAMES[i][11:4]);
			wr(8'h1c, FRAMES[i][7:0]);
			run = 1'b1;
			for (int k = 0; k < 3; k++) begin
				rd = nframes;
				for (int j = 0; j < 1500 && nframes === rd; j++) settle(1);
			end
			check(frame, exp_frame(FRAMES[i]), "frame contents");
		end
		$display("test frames done");
		test_done();
	end
endmodule
